// ===== frsp_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module frsp_cmd #(
	parameter int RECOVERY_CYCLES = frsp_pkg::RECOVERY_CYCLES // reset recovery length
) (
	input wire logic CLK, // core clock 200 MHz
	input wire logic RST_N, // async reset, active low
	input wire logic CS_N, // chip select pin, active low
	input wire logic SCLK, // serial clock pin
	input wire logic [3:0] IO_IN, // io lines in, bit0 is the input line
	output logic [3:0] IO_OUT, // io lines out, bit1 is the output line
	output logic [3:0] IO_OE_N, // io output enables, low drives
	input wire logic QUAD_MODE, // quad_command_mode setting
	input wire logic PERF_MODE, // performance enhance mode active
	input wire logic SUSPEND_ERASE, // pulse: erase suspend entered
	input wire logic SUSPEND_PROGRAM, // pulse: program suspend entered
	input wire logic LATCH_SET, // pulse: write_latch_set_cmd accepted elsewhere
	input wire logic WRITE_START, // pulse: program or erase begun
	input wire logic WRITE_DONE, // pulse: write operation finished
	output var frsp_pkg::frsp_status_t STATUS, // suspend, latch and busy flags
	output logic [7:0] SECURITY, // security register image
	output logic RESUME_GO, // pulse: continue suspended write
	output logic WRITE_ABORT, // pulse: abort write in progress
	output logic SOFT_RESET, // pulse: restore volatile defaults
	output logic READY // not in reset recovery
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [5:0] sync1_reg, sync2_reg;
	logic sclk_old_reg;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_reg <= 6'h01;
			sync2_reg <= 6'h01;
			sclk_old_reg <= 1'b0;
		end else begin
			sync1_reg <= {IO_IN, SCLK, CS_N};
			sync2_reg <= sync1_reg;
			sclk_old_reg <= sync2_reg[1];
		end
	end
	logic cs_n_s, sclk_rise, sclk_fall;
	logic [3:0] io_s;
	assign cs_n_s = sync2_reg[0];
	assign io_s = sync2_reg[5:2];
	assign sclk_rise = !cs_n_s && sync2_reg[1] && !sclk_old_reg;
	assign sclk_fall = !cs_n_s && !sync2_reg[1] && sclk_old_reg;

	// ----------------------------------------
	// byte shifter
	// ----------------------------------------
	logic [7:0] shift_reg, shift_next;
	logic [3:0] bit_cnt_reg;
	logic byte_done;
	always_comb begin
		shift_next = QUAD_MODE ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]};
	end
	assign byte_done = sclk_rise && (bit_cnt_reg + 4'h1 == (QUAD_MODE ? frsp_pkg::BITS_QUAD : frsp_pkg::BITS_SINGLE));
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
		end else if (cs_n_s) begin
			bit_cnt_reg <= 4'h0;
		end else if (sclk_rise) begin
			shift_reg <= shift_next;
			bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_reg + 4'h1;
		end
	end

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	frsp_pkg::frsp_state_t state_reg;
	logic [7:0] opcode_reg;
	logic [2:0] addr_cnt_reg;
	logic [23:0] tbl_addr_reg;
	logic cs_old_reg;
	logic frame_end;
	assign frame_end = cs_n_s && !cs_old_reg;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= frsp_pkg::ST_OPCODE;
			opcode_reg <= 8'h00;
			addr_cnt_reg <= 3'h0;
			tbl_addr_reg <= 24'h000000;
			cs_old_reg <= 1'b1;
		end else begin
			cs_old_reg <= cs_n_s;
			if (cs_n_s) begin
				state_reg <= frsp_pkg::ST_OPCODE;
				addr_cnt_reg <= 3'h0;
			end else if (byte_done) begin
				unique case (state_reg)
					frsp_pkg::ST_OPCODE: begin
						opcode_reg <= shift_next;
						state_reg <= (shift_next == frsp_pkg::OP_PARAM_READ && !QUAD_MODE) ? frsp_pkg::ST_ADDR : frsp_pkg::ST_IGNORE;
					end
					frsp_pkg::ST_ADDR: begin
						if (addr_cnt_reg < 3'(frsp_pkg::ADDR_BYTES))
							tbl_addr_reg <= {tbl_addr_reg[15:0], shift_next};
						addr_cnt_reg <= addr_cnt_reg + 3'h1;
						if (addr_cnt_reg == 3'(frsp_pkg::ADDR_BYTES + frsp_pkg::DUMMY_BYTES - 1))
							state_reg <= frsp_pkg::ST_DATA;
					end
					frsp_pkg::ST_DATA: tbl_addr_reg <= tbl_addr_reg + 24'h000001;
					frsp_pkg::ST_IGNORE: state_reg <= frsp_pkg::ST_IGNORE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// table output
	// ----------------------------------------
	logic [7:0] tbl_byte;
	logic [2:0] out_bit_reg;
	frsp_table_rom u_rom (
		.CLK(CLK),
		.RST_N(RST_N),
		.addr(tbl_addr_reg),
		.rdata(tbl_byte)
	);
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			IO_OUT <= 4'h0;
			IO_OE_N <= 4'hF;
			out_bit_reg <= 3'h7;
		end else if (state_reg != frsp_pkg::ST_DATA || cs_n_s) begin
			IO_OE_N <= 4'hF;
			out_bit_reg <= 3'h7;
		end else if (sclk_fall) begin
			IO_OE_N <= 4'hD;
			IO_OUT <= {2'h0, tbl_byte[out_bit_reg], 1'b0};
			out_bit_reg <= out_bit_reg - 3'h1;
		end
	end

	// ----------------------------------------
	// command execution at frame end
	// ----------------------------------------
	logic armed_reg;
	logic [31:0] recov_cnt_reg;
	logic exec, is_resume, is_reset, is_nop, is_arm;
	logic suspended;
	assign suspended = STATUS.erase_suspended_flag || STATUS.program_suspended_flag;
	assign exec = frame_end && state_reg == frsp_pkg::ST_IGNORE && bit_cnt_reg == 4'h0 && READY;
	assign is_resume = exec && opcode_reg == frsp_pkg::OP_RESUME;
	assign is_nop = exec && opcode_reg == frsp_pkg::OP_NOP;
	assign is_arm = exec && opcode_reg == frsp_pkg::OP_RESET_ARM;
	assign is_reset = exec && opcode_reg == frsp_pkg::OP_SOFT_RESET && armed_reg;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			armed_reg <= 1'b0;
		end else if (frame_end && READY) begin
			armed_reg <= is_arm;
		end
	end

	logic resume_ok;
	assign resume_ok = is_resume && suspended && !PERF_MODE;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			STATUS <= '0;
			RESUME_GO <= 1'b0;
			WRITE_ABORT <= 1'b0;
			SOFT_RESET <= 1'b0;
		end else begin
			RESUME_GO <= resume_ok;
			WRITE_ABORT <= is_reset && STATUS.write_in_progress_flag;
			SOFT_RESET <= is_reset;
			if (is_reset) begin
				STATUS <= '0;
			end else begin
				if (SUSPEND_ERASE || SUSPEND_PROGRAM)
					STATUS.write_enable_latch <= 1'b0;
				else if (LATCH_SET)
					STATUS.write_enable_latch <= 1'b1;
				if (SUSPEND_ERASE)
					STATUS.erase_suspended_flag <= 1'b1;
				else if (resume_ok)
					STATUS.erase_suspended_flag <= frsp_pkg::FLAG_RST;
				if (SUSPEND_PROGRAM)
					STATUS.program_suspended_flag <= 1'b1;
				else if (resume_ok)
					STATUS.program_suspended_flag <= frsp_pkg::FLAG_RST;
				if (WRITE_START || resume_ok)
					STATUS.write_in_progress_flag <= 1'b1;
				else if (WRITE_DONE || SUSPEND_ERASE || SUSPEND_PROGRAM)
					STATUS.write_in_progress_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SECURITY <= 8'h00;
		end else begin
			SECURITY <= {4'h0, STATUS.erase_suspended_flag, STATUS.program_suspended_flag, 2'h0};
		end
	end

	// ----------------------------------------
	// reset recovery
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			recov_cnt_reg <= 32'h00000000;
			READY <= 1'b1;
		end else if (is_reset) begin
			recov_cnt_reg <= 32'(RECOVERY_CYCLES);
			READY <= 1'b0;
		end else if (recov_cnt_reg != 32'h00000000) begin
			recov_cnt_reg <= recov_cnt_reg - 32'h00000001;
			READY <= recov_cnt_reg == 32'h00000001;
		end
	end
endmodule : frsp_cmd
`default_nettype wire

// ===== frsp_pkg.sv
package frsp_pkg;

	// opcodes
	localparam logic [7:0] OP_RESUME = 8'h30;
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_SOFT_RESET = 8'h99;
	localparam logic [7:0] OP_PARAM_READ = 8'h5A;
	localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;

	// parameter table layout
	localparam int TBL_ADDR_W = 7;
	localparam int TBL_DEPTH = 128;
	localparam logic [31:0] TBL_SIGNATURE = 32'h50444653;
	localparam logic [7:0] TBL_MINOR_REV = 8'h00;
	localparam logic [7:0] TBL_MAJOR_REV = 8'h01;
	localparam logic [7:0] TBL_HDR_COUNT = 8'h01;
	localparam logic [7:0] TBL_STD_ID = 8'h00;
	localparam logic [7:0] TBL_STD_LEN = 8'h09;
	localparam logic [23:0] TBL_STD_PTR = 24'h000030;
	// vendor id byte: arbitrary neutral value
	localparam logic [7:0] TBL_VENDOR_ID = 8'h5E;
	localparam logic [7:0] TBL_VENDOR_LEN = 8'h04;
	localparam logic [23:0] TBL_VENDOR_PTR = 24'h000060;
	localparam logic [7:0] TBL_UNUSED = 8'hFF;
	localparam logic [7:0] TBL_OFS_SIG = 8'h00;
	localparam logic [7:0] TBL_OFS_MINOR = 8'h04;
	localparam logic [7:0] TBL_OFS_MAJOR = 8'h05;
	localparam logic [7:0] TBL_OFS_COUNT = 8'h06;
	localparam logic [7:0] TBL_OFS_HDR0 = 8'h08;
	localparam logic [7:0] TBL_OFS_HDR1 = 8'h10;

	// frame field sizes
	localparam int ADDR_BYTES = 3;
	localparam int DUMMY_BYTES = 1;
	localparam logic [3:0] BITS_SINGLE = 4'h8;
	localparam logic [3:0] BITS_QUAD = 4'h2;

	// timing
	localparam int CLK_MHZ = 200;
	localparam int RECOVERY_US = 40;
	localparam int RECOVERY_CYCLES = RECOVERY_US * CLK_MHZ;

	// reset values
	localparam logic FLAG_RST = 1'b0;

	typedef struct packed {
		logic erase_suspended_flag;
		logic program_suspended_flag;
		logic write_enable_latch;
		logic write_in_progress_flag;
	} frsp_status_t;

	typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_IGNORE} frsp_state_t;

endpackage : frsp_pkg

// ===== frsp_table_rom.sv
`timescale 1ns/1ps
`default_nettype none
module frsp_table_rom (
	input wire logic CLK, // core clock
	input wire logic RST_N, // async reset, active low
	input wire logic [23:0] addr, // table byte address
	output logic [7:0] rdata // registered table byte
);
	logic [7:0] tbl [frsp_pkg::TBL_DEPTH];

	// ----------------------------------------
	// table contents
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < frsp_pkg::TBL_DEPTH; gi++) begin : g_byte
			localparam logic [7:0] A = 8'(gi);
			if (A < frsp_pkg::TBL_OFS_MINOR) begin : g_sig
				assign tbl[gi] = frsp_pkg::TBL_SIGNATURE[8*gi +: 8];
			end else if (A == frsp_pkg::TBL_OFS_MINOR) begin : g_mn
				assign tbl[gi] = frsp_pkg::TBL_MINOR_REV;
			end else if (A == frsp_pkg::TBL_OFS_MAJOR) begin : g_mj
				assign tbl[gi] = frsp_pkg::TBL_MAJOR_REV;
			end else if (A == frsp_pkg::TBL_OFS_COUNT) begin : g_cnt
				assign tbl[gi] = frsp_pkg::TBL_HDR_COUNT;
			end else if (A == frsp_pkg::TBL_OFS_HDR0) begin : g_h0
				assign tbl[gi] = frsp_pkg::TBL_STD_ID;
			end else if (A == frsp_pkg::TBL_OFS_HDR0 + 8'h01 || A == frsp_pkg::TBL_OFS_HDR1 + 8'h01) begin : g_rmn
				assign tbl[gi] = frsp_pkg::TBL_MINOR_REV;
			end else if (A == frsp_pkg::TBL_OFS_HDR0 + 8'h02 || A == frsp_pkg::TBL_OFS_HDR1 + 8'h02) begin : g_rmj
				assign tbl[gi] = frsp_pkg::TBL_MAJOR_REV;
			end else if (A == frsp_pkg::TBL_OFS_HDR0 + 8'h03) begin : g_l0
				assign tbl[gi] = frsp_pkg::TBL_STD_LEN;
			end else if (A >= frsp_pkg::TBL_OFS_HDR0 + 8'h04 && A < frsp_pkg::TBL_OFS_HDR0 + 8'h07) begin : g_p0
				assign tbl[gi] = frsp_pkg::TBL_STD_PTR[8*(gi-12) +: 8];
			end else if (A == frsp_pkg::TBL_OFS_HDR1) begin : g_h1
				assign tbl[gi] = frsp_pkg::TBL_VENDOR_ID;
			end else if (A == frsp_pkg::TBL_OFS_HDR1 + 8'h03) begin : g_l1
				assign tbl[gi] = frsp_pkg::TBL_VENDOR_LEN;
			end else if (A >= frsp_pkg::TBL_OFS_HDR1 + 8'h04 && A < frsp_pkg::TBL_OFS_HDR1 + 8'h07) begin : g_p1
				assign tbl[gi] = frsp_pkg::TBL_VENDOR_PTR[8*(gi-20) +: 8];
			end else begin : g_un
				assign tbl[gi] = frsp_pkg::TBL_UNUSED;
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata <= frsp_pkg::TBL_UNUSED;
		end else if (addr >= 24'(frsp_pkg::TBL_DEPTH)) begin
			rdata <= frsp_pkg::TBL_UNUSED;
		end else begin
			rdata <= tbl[addr[frsp_pkg::TBL_ADDR_W-1:0]];
		end
	end
endmodule : frsp_table_rom
`default_nettype wire

// ===== frsp_cmd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module frsp_cmd_asserts #(
	parameter int RECOVERY_CYCLES = frsp_pkg::RECOVERY_CYCLES // recovery length
) (
	input wire logic CLK, // core clock
	input wire logic RST_N, // async reset, active low
	input wire logic CS_N, // chip select
	input wire logic PERF_MODE, // perf mode level
	input wire logic SUSPEND_ERASE, // erase suspend pulse
	input wire logic SUSPEND_PROGRAM, // program suspend pulse
	input wire logic [3:0] IO_OE_N, // line enables
	input wire frsp_pkg::frsp_status_t STATUS, // flags
	input wire logic [7:0] SECURITY, // security image
	input wire logic RESUME_GO, // resume pulse
	input wire logic WRITE_ABORT, // abort pulse
	input wire logic SOFT_RESET, // reset pulse
	input wire logic READY // not in recovery
);
	// ----
	// checks
	// ----
	int low_cnt_reg;
	logic susp;
	assign susp = SUSPEND_ERASE | SUSPEND_PROGRAM;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			low_cnt_reg <= 0;
		end else begin
			low_cnt_reg <= READY ? 0 : low_cnt_reg + 1;
		end
	end
	sequence s_resumed;
		!STATUS.erase_suspended_flag && !STATUS.program_suspended_flag && STATUS.write_in_progress_flag;
	endsequence
	sequence s_not_ready;
		##[0:1] !READY;
	endsequence
	resume_clears_a: assert property (RESUME_GO && !$past(susp) |-> s_resumed)
		else $error("resume left a flag or no busy");
	perf_blocks_a: assert property ($past(PERF_MODE) |-> !RESUME_GO)
		else $error("resume taken in perf mode");
	resume_needs_a: assert property (RESUME_GO |-> $past(STATUS.erase_suspended_flag) || $past(STATUS.program_suspended_flag))
		else $error("resume with nothing suspended");
	reset_clears_a: assert property (SOFT_RESET && !$past(susp) |-> STATUS == 4'h0)
		else $error("soft reset left status");
	recovery_start_a: assert property (SOFT_RESET |-> s_not_ready)
		else $error("ready stayed after soft reset");
	recovery_len_a: assert property ($rose(READY) |-> low_cnt_reg == RECOVERY_CYCLES)
		else $error("recovery length wrong");
	abort_busy_a: assert property (SOFT_RESET && $past(STATUS.write_in_progress_flag) |-> WRITE_ABORT)
		else $error("busy write not aborted");
	security_map_a: assert property (SECURITY[3:2] == {$past(STATUS.erase_suspended_flag), $past(STATUS.program_suspended_flag)})
		else $error("security bits do not follow flags");
	oe_idle_a: assert property (CS_N [*6] |-> IO_OE_N == 4'hF)
		else $error("lines driven while deselected");
endmodule : frsp_cmd_asserts
bind frsp_cmd frsp_cmd_asserts #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) chk (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N),
	.PERF_MODE(PERF_MODE), .SUSPEND_ERASE(SUSPEND_ERASE), .SUSPEND_PROGRAM(SUSPEND_PROGRAM), .IO_OE_N(IO_OE_N),
	.STATUS(STATUS), .SECURITY(SECURITY), .RESUME_GO(RESUME_GO), .WRITE_ABORT(WRITE_ABORT),
	.SOFT_RESET(SOFT_RESET), .READY(READY));
`default_nettype wire

// ===== frsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module frsp_host (
	input wire logic clk, // core clock
	output logic cs_n, // chip select, active low
	output logic sclk, // serial clock, idles low
	output logic [3:0] io_in, // lines toward device
	input wire logic [3:0] io_out, // lines from device
	input wire logic [3:0] oe_n // device enables
);
	// ----
	// host
	// ----
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_in = 4'h0;
	end
	// data set while low, taken by device on rise
	task automatic tick(input logic [3:0] v, output logic so);
		io_in <= v;
		sclk <= 1'b0;
		repeat (7) @(posedge clk);
		// a released output line reads back inverted
		so = oe_n[1] ? ~io_out[1] : io_out[1];
		sclk <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : tick
	task automatic send(input logic [7:0] b, input logic quad);
		logic so;
		if (quad) begin
			tick(b[7:4], so);
			tick(b[3:0], so);
		end else begin
			for (int i = 7; i >= 0; i--) tick({{3{~b[i]}}, b[i]}, so);
		end
	endtask : send
	task automatic open_cs();
		cs_n <= 1'b0;
		repeat (7) @(posedge clk);
	endtask : open_cs
	// released lines must not keep the last value
	task automatic close_cs();
		sclk <= 1'b0;
		repeat (7) @(posedge clk);
		cs_n <= 1'b1;
		io_in <= ~io_in;
		repeat (12) @(posedge clk);
	endtask : close_cs
	task automatic frame(input logic [7:0] op, input logic quad);
		open_cs();
		send(op, quad);
		close_cs();
	endtask : frame
	task automatic read_table(input logic [23:0] a, input int n, output logic [7:0] q [32], output logic drv);
		logic so;
		drv = 1'b1;
		open_cs();
		send(frsp_pkg::OP_PARAM_READ, 1'b0);
		for (int i = 2; i >= 0; i--) send(a[i*8 +: 8], 1'b0);
		send(8'h00, 1'b0);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				tick(4'h0, so);
				q[k][i] = so;
				drv &= (oe_n === 4'hD);
			end
		end
		close_cs();
	endtask : read_table
endmodule : frsp_host
`default_nettype wire

// ===== frsp_cmd_test.sv
`timescale 1ns/1ps
`default_nettype none
module frsp_cmd_test;
	// ----
	// bench
	// ----
	localparam int REC = 20;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic QUAD_MODE = 1'b0;
	logic PERF_MODE = 1'b0;
	logic [4:0] pls = 5'h00; // erase, program, latch, start, done
	logic CS_N, SCLK, RESUME_GO, WRITE_ABORT, SOFT_RESET, READY, drv;
	logic [3:0] IO_IN, IO_OUT, IO_OE_N;
	logic [7:0] SECURITY;
	frsp_pkg::frsp_status_t STATUS;
	int failures = 0;
	int total_checks = 0;
	int n_go = 0;
	int n_sr = 0;
	int n_ab = 0;
	int low_cnt = 0;
	logic [7:0] q [32];
	logic [7:0] tbl [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09,
		8'h30, 8'h00, 8'h00, 8'hFF, frsp_pkg::TBL_VENDOR_ID, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF};
	frsp_cmd #(.RECOVERY_CYCLES(REC)) uut (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SCLK(SCLK), .IO_IN(IO_IN),
		.IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N), .QUAD_MODE(QUAD_MODE), .PERF_MODE(PERF_MODE), .SUSPEND_ERASE(pls[0]),
		.SUSPEND_PROGRAM(pls[1]), .LATCH_SET(pls[2]), .WRITE_START(pls[3]), .WRITE_DONE(pls[4]), .STATUS(STATUS),
		.SECURITY(SECURITY), .RESUME_GO(RESUME_GO), .WRITE_ABORT(WRITE_ABORT), .SOFT_RESET(SOFT_RESET), .READY(READY));
	frsp_host host (.clk(CLK), .cs_n(CS_N), .sclk(SCLK), .io_in(IO_IN), .io_out(IO_OUT), .oe_n(IO_OE_N));
	initial forever #2.5 CLK = ~CLK;
	always @(posedge CLK) begin
		n_go += int'(RESUME_GO === 1'b1);
		n_sr += int'(SOFT_RESET === 1'b1);
		n_ab += int'(WRITE_ABORT === 1'b1);
		low_cnt += int'(READY === 1'b0);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic pulse(input int k);
		pls[k] <= 1'b1;
		@(posedge CLK);
		pls[k] <= 1'b0;
		repeat (3) @(posedge CLK);
	endtask : pulse
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic t_resume();
		int g;
		for (int k = 0; k < 2; k++) begin
			QUAD_MODE <= k[0];
			pulse(2);
			pulse(3);
			check(32'(STATUS), 32'h3);
			pulse(k);
			check(32'(STATUS), k ? 32'h4 : 32'h8);
			check(32'(SECURITY[3:2]), k ? 32'h1 : 32'h2);
			g = n_go;
			host.frame(frsp_pkg::OP_RESUME, k[0]);
			check(n_go - g, 1);
			check(32'(STATUS), 32'h1);
			host.frame(frsp_pkg::OP_RESUME, k[0]);
			check(n_go - g, 1);
			check(32'(STATUS), 32'h1);
			pulse(4); // next suspend hits a new write, never the resumed one
			check(32'(STATUS), 32'h0);
		end
		$display("resume test done");
	endtask : t_resume
	task automatic t_perf();
		int g;
		g = n_go;
		QUAD_MODE <= 1'b0;
		pulse(3);
		pulse(0);
		PERF_MODE <= 1'b1;
		host.frame(frsp_pkg::OP_RESUME, 1'b0);
		check(n_go - g, 0);
		check(32'(STATUS), 32'h8);
		PERF_MODE <= 1'b0;
		host.frame(frsp_pkg::OP_RESUME, 1'b0);
		check(n_go - g, 1);
		$display("perf mode test done");
	endtask : t_perf
	task automatic t_reset();
		int s;
		int a;
		int lc;
		s = n_sr;
		a = n_ab;
		host.frame(frsp_pkg::OP_RESET_ARM, 1'b0);
		host.frame(frsp_pkg::OP_NOP, 1'b0);
		host.frame(frsp_pkg::OP_SOFT_RESET, 1'b0);
		check(n_sr - s, 0);
		check(32'(STATUS), 32'h1);
		QUAD_MODE <= 1'b1;
		lc = low_cnt;
		host.frame(frsp_pkg::OP_RESET_ARM, 1'b1);
		host.frame(frsp_pkg::OP_SOFT_RESET, 1'b1);
		check(n_sr - s, 1);
		check(n_ab - a, 1);
		check(32'(STATUS), 32'h0);
		for (int i = 0; i < 50 && READY !== 1'b1; i++) @(posedge CLK);
		if (READY !== 1'b1) begin
			check(32'(READY), 32'h1);
			tally_and_finish();
		end
		check(low_cnt - lc, REC);
		$display("soft reset test done");
	endtask : t_reset
	task automatic t_table();
		QUAD_MODE <= 1'b0;
		host.read_table(24'h000000, 26, q, drv);
		for (int i = 0; i < 26; i++) check(32'(q[i]), i < 24 ? 32'(tbl[i]) : 32'hFF);
		check(32'(drv), 32'h1);
		check(32'(IO_OE_N), 32'hF);
		host.read_table(24'h00007E, 3, q, drv);
		for (int i = 0; i < 3; i++) check(32'(q[i]), 32'hFF);
		$display("table test done");
	endtask : t_table
	initial begin
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK);
		check(32'(STATUS), 32'h0);
		t_resume();
		t_perf();
		t_reset();
		t_table();
		tally_and_finish();
	end
endmodule : frsp_cmd_test
`default_nettype wire
